//--- shared/door_modes_pkg.sv
// Purpose: Constants, register map and carrier types for the lift door safety mode block.
// Assumes: 25 MHz clock, APB with 32-bit data, one word per register.
// Notes: Settings are held as 8-bit values, 0 to 99.
// Functional notes
// [RULE1] Selector 00 disables low-energy close, opening obstacle and evacuation functions.
// [RULE2] Selector 01 enables those three functions according to their settings.
// [RULE3] Low-energy timer runs only while open, internal, curtains interrupted, close commanded.
// [RULE4] Nonzero setting and expired timer start a reduced-speed close.
// [RULE5] Setting 00 never starts a reduced-speed close.
// [RULE6] Setting 01 to 99 is the delay in seconds; default 30.
// [RULE7] Obstacle while closing, or opening with function active, gives immediate back-step.
// [RULE8] Aux status output configured as error asserts above temperature warning level.
// [RULE9] Finger-guard configuration makes the aux command input the finger-guard signal.
// [RULE10] Closing command removed at floor leads to skate-open parking after a delay.
// [RULE11] Main lift controller withdraws close at floor and reasserts it during travel.
// [RULE12] After the evacuation delay the clutch opens at reduced speed to skate plus offset.
// [RULE13] Low-energy timer clears whenever any enabling condition drops before expiry.
package door_modes_pkg;

  localparam logic [7:0] OFS_CODE_SEL = 8'h00;
  localparam logic [7:0] OFS_LE_TIMEOUT = 8'h04;
  localparam logic [7:0] OFS_OPEN_FORCE = 8'h08;
  localparam logic [7:0] OFS_EVAC_DELAY = 8'h0c;
  localparam logic [7:0] OFS_CONFIG = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;

  localparam logic [1:0] CODE_SEL_OLD = 2'h0;
  localparam logic [1:0] CODE_SEL_NEW = 2'h1;

  localparam logic [7:0] RST_CODE_SEL = 8'h00;
  localparam logic [7:0] RST_LE_TIMEOUT = 8'd30;
  localparam logic [7:0] RST_OPEN_FORCE = 8'd90;
  localparam logic [7:0] RST_EVAC_DELAY = 8'd10;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] SETTING_MAX = 8'd99;

  // Config register fields.
  localparam int CFG_REV_INTERNAL = 0;
  localparam int CFG_AUX_IS_ERROR = 1;
  localparam int CFG_FINGER_GUARD = 2;

  // Interrupt bits.
  localparam int IRQ_LE_CLOSE = 0;
  localparam int IRQ_BACK_STEP = 1;
  localparam int IRQ_OVERHEAT = 2;
  localparam int IRQ_EVAC = 3;
  localparam int IRQ_W = 4;

  localparam int CLK_HZ = 25_000_000;
  localparam int SECOND_CYCLES = CLK_HZ;

  typedef struct packed {
    logic door_open;
    logic curtain_broken;
    logic close_cmd;
    logic car_at_floor;
    logic obstacle;
    logic closing;
    logic opening;
    logic temp_warning;
    logic skate_reached;
  } door_in_t;

  typedef struct packed {
    logic reduced_close;
    logic back_step;
    logic clutch_open;
    logic reduced_speed;
    logic finger_guard;
    logic aux_status;
  } door_out_t;

endpackage

//--- verilog/door_safety_modes.sv
// Purpose: Code-standard gated safety functions of a lift door drive with APB registers.
// Assumes: Inputs synchronous to clock_i; motion sequencing outside acts on the command outputs.
// Notes: A one-second prescaler feeds both delay counters.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module door_safety_modes
  import door_modes_pkg::*;
#(
  parameter int SEC_CYCLES = SECOND_CYCLES
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire door_in_t door_i,
  input wire logic aux_command_input_i,
  output door_out_t door_o,
  output logic irq_o
);

  typedef enum logic [3:0] {
    EV_IDLE = 4'b0001,
    EV_WAIT = 4'b0010,
    EV_OPENING = 4'b0100,
    EV_PARKED = 4'b1000
  } evac_state_t;

  function automatic logic [7:0] clamp_setting(input logic [31:0] v);
    clamp_setting = (v > 32'(SETTING_MAX)) ? SETTING_MAX : v[7:0];
  endfunction

  logic [7:0] code_sel_q;
  logic [7:0] low_energy_close_timeout_q;
  logic [7:0] opening_obstacle_force_q;
  logic [7:0] evacuation_relax_delay_q;
  logic [7:0] config_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [31:0] prdata_q;
  logic [31:0] presc_q;
  logic [7:0] le_sec_q;
  logic [7:0] ev_sec_q;
  logic le_close_q;
  logic back_step_q;
  logic aux_q;
  logic finger_q;
  logic prev_close_q;
  evac_state_t ev_state_q;
  evac_state_t ev_state_d;

  wire access = psel_i & penable_i;
  wire wr = access & pwrite_i & clk_en_i;
  // Read data is captured in the setup cycle so that it stands through the access phase.
  wire rd = psel_i & ~penable_i & ~pwrite_i & clk_en_i;
  wire addr_ok = (paddr_i[7:5] == 3'b000) & (paddr_i[1:0] == 2'b00);
  wire new_code = (code_sel_q[1:0] == CODE_SEL_NEW); // RULE2
  // Selector 00 forces all three newer functions off regardless of settings.
  wire le_enabled = new_code & (low_energy_close_timeout_q != 8'h00); // RULE1 RULE5
  wire open_obst_enabled = new_code & (opening_obstacle_force_q != 8'h00); // RULE1
  wire evac_enabled = new_code & (evacuation_relax_delay_q != 8'h00); // RULE1
  wire tick = (presc_q == 32'(SEC_CYCLES - 1));
  wire le_cond = door_i.door_open & config_q[CFG_REV_INTERNAL] & door_i.curtain_broken
                 & door_i.close_cmd; // RULE3
  wire le_expire = le_enabled & le_cond & tick & (le_sec_q == low_energy_close_timeout_q - 8'd1); // RULE6
  wire finger_sel = config_q[CFG_FINGER_GUARD] & aux_command_input_i; // RULE9
  wire obstacle_hit = door_i.obstacle | finger_sel;
  wire back_step_d = obstacle_hit & (door_i.closing | (door_i.opening & open_obst_enabled)); // RULE7
  wire aux_d = config_q[CFG_AUX_IS_ERROR] & door_i.temp_warning; // RULE8
  wire close_removed = prev_close_q & ~door_i.close_cmd;
  wire ev_expire = (ev_state_q == EV_WAIT) & tick & (ev_sec_q == evacuation_relax_delay_q - 8'd1);
  wire [IRQ_W-1:0] irq_ev;
  assign irq_ev[IRQ_LE_CLOSE] = le_expire;
  assign irq_ev[IRQ_BACK_STEP] = back_step_d & ~back_step_q;
  assign irq_ev[IRQ_OVERHEAT] = aux_d & ~aux_q;
  assign irq_ev[IRQ_EVAC] = ev_expire;

  wire [31:0] status_word = {26'h000_0000, ev_state_q == EV_PARKED, ev_state_q == EV_OPENING,
                             ev_state_q == EV_WAIT, aux_q, back_step_q, le_close_q};
  wire [31:0] rd_mux =
    (paddr_i == OFS_CODE_SEL) ? {24'h00_0000, code_sel_q} :
    (paddr_i == OFS_LE_TIMEOUT) ? {24'h00_0000, low_energy_close_timeout_q} :
    (paddr_i == OFS_OPEN_FORCE) ? {24'h00_0000, opening_obstacle_force_q} :
    (paddr_i == OFS_EVAC_DELAY) ? {24'h00_0000, evacuation_relax_delay_q} :
    (paddr_i == OFS_CONFIG) ? {24'h00_0000, config_q} :
    (paddr_i == OFS_STATUS) ? status_word :
    (paddr_i == OFS_IRQ_STATUS) ? {28'h000_0000, irq_stat_q} :
    (paddr_i == OFS_IRQ_MASK) ? {28'h000_0000, irq_mask_q} : 32'h0000_0000;

  assign pready_o = 1'b1;
  assign pslverr_o = access & ~addr_ok;
  assign prdata_o = prdata_q;
  assign irq_o = |(irq_stat_q & irq_mask_q);
  assign door_o.reduced_close = le_close_q; // RULE4
  assign door_o.back_step = back_step_q;
  assign door_o.clutch_open = (ev_state_q == EV_OPENING) | (ev_state_q == EV_PARKED);
  assign door_o.reduced_speed = le_close_q | (ev_state_q == EV_OPENING); // RULE12
  assign door_o.finger_guard = finger_q;
  assign door_o.aux_status = aux_q;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      code_sel_q <= RST_CODE_SEL;
      low_energy_close_timeout_q <= RST_LE_TIMEOUT;
      opening_obstacle_force_q <= RST_OPEN_FORCE;
      evacuation_relax_delay_q <= RST_EVAC_DELAY;
      config_q <= RST_CONFIG;
      irq_mask_q <= '0;
      prdata_q <= 32'h0000_0000;
    end else if (clk_en_i) begin
      if (wr && paddr_i == OFS_CODE_SEL) begin
        code_sel_q <= {6'h00, pwdata_i[1:0]};
      end
      if (wr && paddr_i == OFS_LE_TIMEOUT) begin
        low_energy_close_timeout_q <= clamp_setting(pwdata_i);
      end
      if (wr && paddr_i == OFS_OPEN_FORCE) begin
        opening_obstacle_force_q <= clamp_setting(pwdata_i);
      end
      if (wr && paddr_i == OFS_EVAC_DELAY) begin
        evacuation_relax_delay_q <= clamp_setting(pwdata_i);
      end
      if (wr && paddr_i == OFS_CONFIG) begin
        config_q <= {5'h00, pwdata_i[2:0]};
      end
      if (wr && paddr_i == OFS_IRQ_MASK) begin
        irq_mask_q <= pwdata_i[IRQ_W-1:0];
      end
      if (rd) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // A new event in the clearing cycle keeps its bit set.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_stat_q <= '0;
    end else if (clk_en_i) begin
      irq_stat_q <= (irq_stat_q & ~((wr && paddr_i == OFS_IRQ_STATUS) ? pwdata_i[IRQ_W-1:0] : '0)) | irq_ev;
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      presc_q <= 32'h0000_0000;
    end else if (clk_en_i) begin
      presc_q <= tick ? 32'h0000_0000 : presc_q + 32'h0000_0001;
    end
  end

  // Low-energy close timer and latch.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      le_sec_q <= 8'h00;
      le_close_q <= 1'b0;
    end else if (clk_en_i) begin
      if (!(le_enabled && le_cond)) begin
        le_sec_q <= 8'h00; // RULE13
      end else if (tick && !le_close_q) begin
        le_sec_q <= le_sec_q + 8'h01; // RULE3
      end
      if (le_expire) begin
        le_close_q <= 1'b1; // RULE4
      end else if (!door_i.close_cmd || !le_enabled || door_i.obstacle) begin
        le_close_q <= 1'b0; // RULE5
      end
    end
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      back_step_q <= 1'b0;
      aux_q <= 1'b0;
      finger_q <= 1'b0;
      prev_close_q <= 1'b0;
    end else if (clk_en_i) begin
      back_step_q <= back_step_d; // RULE7
      aux_q <= aux_d; // RULE8
      finger_q <= finger_sel; // RULE9
      prev_close_q <= door_i.close_cmd;
    end
  end

  // Evacuation parking sequence; depends on the controller dropping close at floor.
  always_comb begin
    ev_state_d = ev_state_q;
    case (ev_state_q)
      EV_IDLE: begin
        if (evac_enabled && door_i.car_at_floor && close_removed) begin
          ev_state_d = EV_WAIT; // RULE10 RULE11
        end
      end
      EV_WAIT: begin
        if (door_i.close_cmd || !evac_enabled || !door_i.car_at_floor) begin
          ev_state_d = EV_IDLE;
        end else if (ev_expire) begin
          ev_state_d = EV_OPENING; // RULE12
        end
      end
      EV_OPENING: begin
        if (door_i.close_cmd || !evac_enabled) begin
          ev_state_d = EV_IDLE;
        end else if (door_i.skate_reached) begin
          ev_state_d = EV_PARKED; // RULE12
        end
      end
      EV_PARKED: begin
        if (door_i.close_cmd || !evac_enabled) begin
          ev_state_d = EV_IDLE;
        end
      end
      default: begin
        ev_state_d = EV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ev_state_q <= EV_IDLE;
      ev_sec_q <= 8'h00;
    end else if (clk_en_i) begin
      ev_state_q <= ev_state_d;
      if (ev_state_q != EV_WAIT) begin
        ev_sec_q <= 8'h00;
      end else if (tick) begin
        ev_sec_q <= ev_sec_q + 8'h01; // RULE10
      end
    end
  end

endmodule // door_safety_modes

//--- sim/door_modes_monitor.sv
// Purpose: Port assertions for the door safety mode block.
// Assumes: Settings are written below 100 and clk_en_i stays high.
// Notes: Settings are shadowed from APB writes, since the checker sees only ports.
`timescale 1ns/1ps
module door_modes_monitor
  import door_modes_pkg::*;
#(parameter int SEC_CYCLES = 10) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic pslverr_o,
  input wire door_in_t door_i,
  input wire logic aux_command_input_i,
  input wire door_out_t door_o
);
  logic [7:0] sel_q, cfg_q, to_q, frc_q, dl_q;
  int le_cnt, ev_cnt;
  wire wr = psel_i & penable_i & pwrite_i & clk_en_i;
  wire new_code = sel_q[1:0] == CODE_SEL_NEW;
  wire le_ok = door_i.door_open & door_i.curtain_broken & door_i.close_cmd & cfg_q[CFG_REV_INTERNAL];
  wire fg_exp = cfg_q[CFG_FINGER_GUARD] & aux_command_input_i;
  wire bs_exp = (door_i.obstacle | fg_exp) & (door_i.closing | door_i.opening & new_code & frc_q != 8'h00);
  wire aux_exp = cfg_q[CFG_AUX_IS_ERROR] & door_i.temp_warning;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_q <= RST_CODE_SEL;
      cfg_q <= RST_CONFIG;
      to_q <= RST_LE_TIMEOUT;
      frc_q <= RST_OPEN_FORCE;
      dl_q <= RST_EVAC_DELAY;
      le_cnt <= 0;
      ev_cnt <= 0;
    end else begin
      if (wr && paddr_i == OFS_CODE_SEL) sel_q <= pwdata_i[7:0];
      if (wr && paddr_i == OFS_CONFIG) cfg_q <= pwdata_i[7:0];
      if (wr && paddr_i == OFS_LE_TIMEOUT) to_q <= pwdata_i[7:0];
      if (wr && paddr_i == OFS_OPEN_FORCE) frc_q <= pwdata_i[7:0];
      if (wr && paddr_i == OFS_EVAC_DELAY) dl_q <= pwdata_i[7:0];
      le_cnt <= (le_ok && new_code && to_q != 8'h00) ? le_cnt + 1 : 0;
      ev_cnt <= (!door_i.close_cmd && door_i.car_at_floor) ? ev_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  a_old_code_quiet: assert property (!new_code |=> !door_o.reduced_close && !door_o.clutch_open)
    else $error("function active under old code");
  a_le_conditions: assert property ($rose(door_o.reduced_close) |-> $past(le_ok) && new_code)
    else $error("low energy close without its conditions");
  a_le_zero_off: assert property (to_q == 8'h00 |=> !$rose(door_o.reduced_close))
    else $error("low energy close with zero setting");
  a_le_delay_time: assert property ($rose(door_o.reduced_close) |->
    le_cnt >= (to_q - 1) * SEC_CYCLES && le_cnt <= to_q * SEC_CYCLES + 2)
    else $error("low energy close delay wrong");
  a_back_step_now: assert property (door_o.back_step == $past(bs_exp))
    else $error("back-step mismatch");
  a_aux_warning: assert property (door_o.aux_status == $past(aux_exp, 1))
    else $error("aux status mismatch");
  a_finger_guard: assert property (door_o.finger_guard == $past(fg_exp))
    else $error("finger guard mismatch");
  a_evac_delay_time: assert property ($rose(door_o.clutch_open) |->
    ev_cnt >= (dl_q - 1) * SEC_CYCLES && ev_cnt <= dl_q * SEC_CYCLES + 2)
    else $error("evacuation delay wrong");
  a_clutch_slow: assert property ($rose(door_o.clutch_open) |-> door_o.reduced_speed)
    else $error("clutch opened at full speed");
  a_close_ends_evac: assert property (door_i.close_cmd |=> !door_o.clutch_open)
    else $error("clutch open under close command");
  a_unmapped_error: assert property (psel_i && penable_i && paddr_i >= 8'h20 |-> pslverr_o)
    else $error("unmapped access without error");
  cover property ($rose(door_o.reduced_close));
  cover property ($rose(door_o.clutch_open));
  cover property ($rose(door_o.back_step) && door_i.opening);
  cover property ($rose(door_o.aux_status));
endmodule // door_modes_monitor
bind door_safety_modes door_modes_monitor #(.SEC_CYCLES(SEC_CYCLES)) door_modes_monitor_inst (.*);

//--- sim/lift_ctrl_model.sv
// Purpose: Main lift controller model driving the close command and floor status.
// Assumes: park_i asks the car to park at floor; low means travel.
// Notes: lag_i sets how slowly the close command is withdrawn.
`timescale 1ns/1ps
module lift_ctrl_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic park_i,
  input wire logic [3:0] lag_i,
  output logic close_cmd_o,
  output logic at_floor_o
);
  logic [3:0] wait_q;
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      close_cmd_o <= 1'b1;
      at_floor_o <= 1'b0;
      wait_q <= 4'h0;
    end else if (park_i) begin
      at_floor_o <= 1'b1;
      wait_q <= (wait_q == lag_i) ? wait_q : wait_q + 4'h1;
      close_cmd_o <= !(at_floor_o && wait_q == lag_i);
    end else begin
      // The car leaves the floor only once the close command is back.
      close_cmd_o <= 1'b1;
      at_floor_o <= at_floor_o & !close_cmd_o;
      wait_q <= 4'h0;
    end
  end
endmodule // lift_ctrl_model

//--- sim/testbench.sv
// Purpose: Self-checking bench for the door safety mode block.
// Assumes: SEC_CYCLES of 10 and clk_en_i held high.
// Notes: Random inputs come from a fixed seed.
`timescale 1ns/1ps
module testbench;
  import door_modes_pkg::*;
  localparam int SEC = 10;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, aux = 1'b0, park = 1'b0;
  logic pready, pslverr, irq, close_w, floor_w, e;
  logic [3:0] lag = 4'h0;
  logic [7:0] paddr = 8'h00, cfg, frc;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [7:0] rv [5] = '{RST_CODE_SEL, RST_LE_TIMEOUT, RST_OPEN_FORCE, RST_EVAC_DELAY, RST_CONFIG};
  door_in_t din = '0;
  door_in_t door_w;
  door_out_t dout;
  integer seed = 32'h98b5;
  int miscompares = 0, n_tests = 0, t, n;
  assign door_w = door_in_t'({din[8:7], close_w, floor_w, din[4:0]});
  always #20 clock_i = ~clock_i;
  door_safety_modes #(.SEC_CYCLES(SEC)) door_safety_modes_inst (.clock_i(clock_i), .arst_n_i(arst_n_i),
    .clk_en_i(1'b1), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .door_i(door_w), .aux_command_input_i(aux),
    .door_o(dout), .irq_o(irq));
  lift_ctrl_model lift_ctrl_model_inst (.clock_i(clock_i), .arst_n_i(arst_n_i), .park_i(park), .lag_i(lag),
    .close_cmd_o(close_w), .at_floor_o(floor_w));
  task automatic conclude();
    $display("checks %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Read data stands through the access phase and is taken at the edge where pready is seen.
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge clock_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge clock_i);
    pen <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clock_i);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      miscompares++;
      conclude();
    end
    e = pslverr;
    r = prdata;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clock_i);
    #1;
  endtask
  task automatic wait_out(input int b, input int lim, input bit must);
    for (t = 0; t < lim; t++) begin
      @(posedge clock_i);
      #1;
      if (dout[b] === 1'b1) break;
    end
    if (must && t == lim) begin
      miscompares++;
      conclude();
    end
  endtask
  function automatic logic [2:0] exp3();
    logic fg;
    fg = cfg[CFG_FINGER_GUARD] & aux;
    return {(din.obstacle | fg) & (din.closing | din.opening & frc != 8'h00), fg, cfg[1] & din.temp_warning};
  endfunction
  initial begin
    repeat (100000) @(posedge clock_i);
    miscompares++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clock_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 8'h00);
      chk("reset value", {24'h00_0000, rv[i]}, r);
    end
    apb(1'b0, 8'h20, 8'h00);
    chk("unmapped", 32'h0000_0001, {r[30:0], e});
    apb(1'b1, OFS_CONFIG, 8'h01);
    @(posedge clock_i);
    din.door_open <= 1'b1;
    din.curtain_broken <= 1'b1;
    wait_out(5, 320, 1'b0);
    chk("old code low energy", 320, t);
    @(posedge clock_i);
    din <= '0;
    park <= 1'b1;
    wait_out(3, 130, 1'b0);
    chk("old code evacuation", 130, t);
    @(posedge clock_i);
    park <= 1'b0;
    apb(1'b1, OFS_CODE_SEL, 8'(CODE_SEL_NEW));
    apb(1'b1, OFS_LE_TIMEOUT, 8'h00);
    @(posedge clock_i);
    din.door_open <= 1'b1;
    din.curtain_broken <= 1'b1;
    wait_out(5, 100, 1'b0);
    chk("zero timeout", 100, t);
    for (int k = 0; k < 3; k++) begin
      n = (k == 2) ? 99 : 1 + ($unsigned($random(seed)) % 4);
      apb(1'b1, OFS_LE_TIMEOUT, 8'(n));
      @(posedge clock_i);
      din.door_open <= 1'b1;
      din.curtain_broken <= 1'b0;
      repeat (SEC / 2 + k) @(posedge clock_i);
      din.curtain_broken <= 1'b1;
      wait_out(5, n * SEC + 20, 1'b1);
      chk("low energy delay", 1, 32'(t >= (n - 1) * SEC && t <= n * SEC + 2));
      @(posedge clock_i);
      din <= '0;
      din.obstacle <= 1'b1;
      repeat (2) @(posedge clock_i);
      din.obstacle <= 1'b0;
      repeat (2) @(posedge clock_i);
      #1 chk("low energy released", 0, 32'(dout.reduced_close));
    end
    for (int i = 0; i < 40; i++) begin
      if (i % 10 == 0) begin
        cfg = {5'h00, 2'($random(seed)), 1'b0};
        frc = (i < 20) ? 8'h00 : 8'(1 + ($unsigned($random(seed)) % 99));
        apb(1'b1, OFS_CONFIG, cfg);
        apb(1'b1, OFS_OPEN_FORCE, frc);
      end
      @(posedge clock_i);
      {din.obstacle, din.closing, din.opening, din.temp_warning, aux} <= 5'($random(seed));
      @(posedge clock_i);
      #1 chk("safety outputs", 32'(exp3()), 32'({dout.back_step, dout.finger_guard, dout.aux_status}));
    end
    @(posedge clock_i);
    din <= door_in_t'(9'h018);
    aux <= 1'b0;
    @(posedge clock_i);
    din <= '0;
    apb(1'b0, OFS_IRQ_STATUS, 8'h00);
    chk("back-step flag and masked irq", 32'h0000_0002, {30'h0000_0000, r[IRQ_BACK_STEP], irq});
    apb(1'b1, OFS_IRQ_MASK, 8'(1 << IRQ_BACK_STEP));
    chk("irq raised", 1, 32'(irq));
    apb(1'b1, OFS_IRQ_STATUS, 8'h0f);
    chk("irq cleared", 0, 32'(irq));
    n = 1 + ($unsigned($random(seed)) % 3);
    apb(1'b1, OFS_EVAC_DELAY, 8'(n));
    @(posedge clock_i);
    lag <= 4'($random(seed));
    park <= 1'b1;
    wait_out(3, n * SEC + 40, 1'b1);
    chk("evacuation wait", 1, 32'(t >= (n - 1) * SEC));
    chk("clutch at reduced speed", 1, 32'(dout.reduced_speed));
    @(posedge clock_i);
    din.skate_reached <= 1'b1;
    repeat (3) @(posedge clock_i);
    park <= 1'b0;
    #1 chk("parked skate open", 1, 32'(dout.clutch_open));
    repeat (4) @(posedge clock_i);
    #1 chk("clutch closed for travel", 0, 32'(dout.clutch_open));
    @(posedge clock_i);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    arst_n_i <= 1'b1;
    apb(1'b0, OFS_CODE_SEL, 8'h00);
    chk("code after reset", 32'(RST_CODE_SEL), r);
    conclude();
  end
endmodule // testbench
